/* File: src/gipb_pkg.sv */
// Shared constants for the general purpose pin bank.
// Assumes a single 250 MHz clock and a synchronous active-high reset.
package gipb_pkg;

    // ==========================================================
    // Geometry
    localparam int NUM_BANKS = 9;
    localparam int BANK_W    = 8;
    localparam int NUM_PINS  = NUM_BANKS * BANK_W;
    localparam int OD_MODS   = 6;

    // ==========================================================
    // Bank indices, in select-code order
    localparam logic [3:0] BANK_A = 4'h0;
    localparam logic [3:0] BANK_B = 4'h1;
    localparam logic [3:0] BANK_C = 4'h2;
    localparam logic [3:0] BANK_D = 4'h3;
    localparam logic [3:0] BANK_E = 4'h4;
    localparam logic [3:0] BANK_F = 4'h5;
    localparam logic [3:0] BANK_G = 4'h6;
    localparam logic [3:0] BANK_H = 4'h7;
    localparam logic [3:0] BANK_J = 4'h8;

    // ==========================================================
    // Register selects within one bank
    localparam logic [1:0] REG_PIN  = 2'h0;
    localparam logic [1:0] REG_DIR  = 2'h1;
    localparam logic [1:0] REG_HOLD = 2'h2;

    // ==========================================================
    // Field positions in the bank G registers
    localparam int PU_D_BIT = 7;
    localparam int PU_E_BIT = 6;
    localparam int PU_J_BIT = 5;
    localparam int OD_LO    = 5;
    localparam int OD_HI    = 7;

    // ==========================================================
    // Reset values
    localparam logic [7:0] DIR_RST  = 8'hFF;
    localparam logic [7:0] HOLD_RST = 8'h00;
    localparam logic [2:0] PU_RST   = 3'h0;
    localparam logic [7:0] RD_ZERO  = 8'h00;

    // Open-drain module codes seen per pin; zero means none.
    typedef enum logic [2:0] {
        GIPB_OD_NONE  = 3'h0,
        GIPB_OD_SER1  = 3'h1,
        GIPB_OD_SER2  = 3'h2,
        GIPB_OD_SPI   = 3'h3,
        GIPB_OD_CC1   = 3'h4,
        GIPB_OD_CC2   = 3'h5,
        GIPB_OD_CC3   = 3'h6
    } gipb_od_type;

endpackage

/* File: src/gipb_bank.sv */
// General purpose pin bank: nine 8-bit banks with direction, output hold
// and pin-level paths, peripheral takeover, pull-ups and open drain.
// Assumes pins are sampled here through a two-stage synchroniser and the
// pad cell resolves the wire level from pin_out and pin_oe.
//
// What this block does
// - Nine banks, each with direction, pin-level and output hold registers.
// - Direction bit one makes the pin an input with driver released.
// - Direction bit zero drives the pin from its output hold bit.
// - Reading the pin-level register returns sampled pin levels, except bank G bits 7:5.
// - Writing the pin-level register writes the output hold register.
// - Reading the output hold register returns latched values, not pins.
// - An enabled peripheral takes the pin over from general purpose use.
// - Only banks B, D, E and J have weak pull-ups.
// - One pull-up enable per bank; B external, D E J in bank G bits 7:5.
// - Open drain only on serial, SPI and capture/compare outputs.
// - Open drain enabled per module by bits in bank G direction and hold.
// - Open drain drives low only; an outside resistor pulls high.
`timescale 1ns/1ps

module gipb_bank
    import gipb_pkg::*;
(
    // Clock and reset
    input  wire logic                          ref_clk,
    input  wire logic                          sys_rst,
    // Software register access
    input  wire logic                          wr_en,
    input  wire logic                          rd_en,
    input  wire logic [3:0]                    bank_sel,
    input  wire logic [1:0]                    reg_sel,
    input  wire logic [7:0]                    wr_data,
    output logic      [7:0]                    rd_data,
    output logic                               rd_valid,
    // Pull-up enable for bank B, held in interrupt_control_two bit 7
    input  wire logic                          bank_b_pullup_enable,
    // Peripheral side, one bit per pin, plus a 3-bit open-drain module code per pin
    input  wire logic [NUM_PINS-1:0]           periph_en,
    input  wire logic [NUM_PINS-1:0]           periph_out,
    input  wire logic [NUM_PINS-1:0]           periph_oe,
    input  wire logic [NUM_PINS-1:0][2:0]      periph_od_mod,
    // Pads
    input  wire logic [NUM_PINS-1:0]           pin_in,
    output logic      [NUM_PINS-1:0]           pin_out,
    output logic      [NUM_PINS-1:0]           pin_oe,
    output logic      [NUM_PINS-1:0]           pin_pullup
);

    // ==========================================================
    // Storage
    logic [7:0]          dir  [NUM_BANKS];
    logic [7:0]          hold [NUM_BANKS];
    logic [2:0]          pu_dej;
    logic [NUM_PINS-1:0] sync_a;
    logic [NUM_PINS-1:0] sync_b;
    logic                sel_ok;
    logic [OD_MODS-1:0]  od_en;
    logic [NUM_PINS-1:0] od_act;
    logic [7:0]          next_rd;

    assign sel_ok = (bank_sel < 4'(NUM_BANKS));

    // ==========================================================
    // Input synchroniser
    // two-stage synchroniser
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            sync_a <= '0;
            sync_b <= '0;
        end
        else
        begin
            sync_a <= pin_in;
            sync_b <= sync_a;
        end
    end

    // ==========================================================
    // Register writes
    // per-bank register set
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            for (int b = 0; b < NUM_BANKS; b++)
            begin
                dir[b]  <= DIR_RST;
                hold[b] <= HOLD_RST;
            end
        end
        else if (wr_en && sel_ok)
        begin
            if (reg_sel == REG_DIR)
            begin
                dir[bank_sel] <= wr_data;
            end
            else if ((reg_sel == REG_PIN) || (reg_sel == REG_HOLD))
            begin
                hold[bank_sel] <= wr_data;
            end
        end
    end

    // Bank G pin register carries the D, E and J pull-up enables in its top bits.
    // bank G pull-up bits
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            pu_dej <= PU_RST;
        end
        else if (wr_en && (bank_sel == BANK_G) && (reg_sel == REG_PIN))
        begin
            pu_dej <= wr_data[PU_D_BIT:PU_J_BIT];
        end
    end

    // ==========================================================
    // Register reads
    always_comb
    begin
        next_rd = RD_ZERO;
        if (!sel_ok)
        begin
            next_rd = RD_ZERO;
        end
        else if (reg_sel == REG_PIN)
        begin
            next_rd = sync_b[bank_sel*BANK_W +: BANK_W];
            if (bank_sel == BANK_G)
            begin
                next_rd[PU_D_BIT:PU_J_BIT] = pu_dej;
            end
        end
        else if (reg_sel == REG_DIR)
        begin
            next_rd = dir[bank_sel];
        end
        else if (reg_sel == REG_HOLD)
        begin
            next_rd = hold[bank_sel];
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            rd_data  <= RD_ZERO;
            rd_valid <= 1'b0;
        end
        else
        begin
            rd_valid <= rd_en;
            if (rd_en)
            begin
                rd_data <= next_rd;
            end
        end
    end

    // ==========================================================
    // Pad drive
    // Open-drain enables: direction bits 7:5 then hold bits 7:5 of bank G.
    // module open-drain bits
    assign od_en = {hold[BANK_G][OD_HI:OD_LO], dir[BANK_G][OD_HI:OD_LO]};

    always_comb
    begin
        for (int p = 0; p < NUM_PINS; p++)
        begin
            // only tagged module outputs
            // Code 7 names no module, so it must never index past the enables.
            od_act[p] = periph_en[p] && (periph_od_mod[p] != GIPB_OD_NONE)
                        && (periph_od_mod[p] <= GIPB_OD_CC3)
                        && od_en[periph_od_mod[p] - 3'h1];
            if (od_act[p])
            begin
                pin_out[p] = 1'b0;
                pin_oe[p]  = periph_oe[p] && !periph_out[p];
            end
            else if (periph_en[p])
            begin
                pin_out[p] = periph_out[p];
                pin_oe[p]  = periph_oe[p];
            end
            else
            begin
                pin_out[p] = hold[p / BANK_W][p % BANK_W];
                pin_oe[p]  = !dir[p / BANK_W][p % BANK_W];
            end
        end
    end

    // Pull-ups are a weak bias; the pad ignores them while the pin is driven.
    // pull-ups on B, D, E, J only
    always_comb
    begin
        pin_pullup = '0;
        pin_pullup[BANK_B*BANK_W +: BANK_W] = {BANK_W{bank_b_pullup_enable}};
        pin_pullup[BANK_D*BANK_W +: BANK_W] = {BANK_W{pu_dej[2]}};
        pin_pullup[BANK_E*BANK_W +: BANK_W] = {BANK_W{pu_dej[1]}};
        pin_pullup[BANK_J*BANK_W +: BANK_W] = {BANK_W{pu_dej[0]}};
    end

    // ==========================================================
    // Checks
    logic [NUM_PINS-1:0] gpio_pin;
    logic [7:0]          sel_hold;
    logic [NUM_PINS-1:0] hold_flat;
    logic [NUM_PINS-1:0] dir_flat;

    always_comb
    begin
        for (int p = 0; p < NUM_PINS; p++)
        begin
            hold_flat[p] = hold[p / BANK_W][p % BANK_W];
            dir_flat[p]  = dir[p / BANK_W][p % BANK_W];
        end
    end
    assign gpio_pin = ~periph_en;
    assign sel_hold = sel_ok ? hold[bank_sel] : RD_ZERO;

    sequence s_pin_read;
        rd_en && !wr_en && sel_ok && (reg_sel == REG_PIN) && (bank_sel != BANK_G);
    endsequence

    sequence s_pin_write;
        wr_en && sel_ok && (reg_sel == REG_PIN);
    endsequence

    property p_input_released;
        @(posedge ref_clk) disable iff (sys_rst)
        ((pin_oe & gpio_pin & dir_flat) == '0);
    endproperty
    a_input_released: assert property (p_input_released)
        else $error("input pin driver not released");

    property p_output_drives_hold;
        @(posedge ref_clk) disable iff (sys_rst)
        (((pin_oe ^ ~dir_flat) & gpio_pin) == '0)
        && (((pin_out ^ hold_flat) & gpio_pin) == '0);
    endproperty
    a_output_drives_hold: assert property (p_output_drives_hold)
        else $error("output pin does not follow hold latch");

    // The bank is taken at the read edge; the select two cycles back may differ.
    property p_pin_read_levels;
        logic [NUM_PINS-1:0] v;
        logic [3:0]          b;
        @(posedge ref_clk) disable iff (sys_rst)
        ##2 (s_pin_read, v = $past(pin_in, 2), b = bank_sel)
        |=> (rd_valid && (rd_data == v[b*BANK_W +: BANK_W]));
    endproperty
    a_pin_read_levels: assert property (p_pin_read_levels)
        else $error("pin read did not return synchronised levels");

    property p_pin_write_hold;
        logic [7:0] v;
        logic [3:0] b;
        @(posedge ref_clk) disable iff (sys_rst)
        (s_pin_write, v = wr_data, b = bank_sel) |=> (hold[b] == v);
    endproperty
    a_pin_write_hold: assert property (p_pin_write_hold)
        else $error("pin write did not reach hold latch");

    property p_hold_read;
        @(posedge ref_clk) disable iff (sys_rst)
        (rd_en && !wr_en && reg_sel == REG_HOLD) |=> (rd_data == $past(sel_hold));
    endproperty
    a_hold_read: assert property (p_hold_read)
        else $error("hold read returned wrong value");

    property p_periph_takeover;
        @(posedge ref_clk) disable iff (sys_rst)
        ((periph_en & ~od_act & (pin_out ^ periph_out)) == '0)
        && ((periph_en & ~od_act & (pin_oe ^ periph_oe)) == '0);
    endproperty
    a_periph_takeover: assert property (p_periph_takeover)
        else $error("peripheral did not own its pin");

    property p_pullup_banks;
        @(posedge ref_clk) disable iff (sys_rst)
        (pin_pullup[BANK_A*BANK_W +: BANK_W] == '0)
        && (pin_pullup[BANK_C*BANK_W +: BANK_W] == '0)
        && (pin_pullup[BANK_F*BANK_W +: 3*BANK_W] == '0);
    endproperty
    a_pullup_banks: assert property (p_pullup_banks)
        else $error("pull-up on a bank without the option");

    property p_pullup_g_bits;
        @(posedge ref_clk) disable iff (sys_rst)
        (wr_en && bank_sel == BANK_G && reg_sel == REG_PIN)
        |=> (pin_pullup[BANK_D*BANK_W] == $past(wr_data[PU_D_BIT]))
            && (pin_pullup[BANK_E*BANK_W + 3] == $past(wr_data[PU_E_BIT]))
            && (pin_pullup[BANK_J*BANK_W + 7] == $past(wr_data[PU_J_BIT]))
            && (pin_pullup[BANK_B*BANK_W +: BANK_W] == {BANK_W{bank_b_pullup_enable}});
    endproperty
    a_pullup_g_bits: assert property (p_pullup_g_bits)
        else $error("pull-up enable bits not applied");

    property p_open_drain;
        @(posedge ref_clk) disable iff (sys_rst)
        ((od_act & pin_out) == '0) && ((od_act & pin_oe & periph_out) == '0)
        && ((od_act & ~periph_en) == '0);
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("open-drain pin drove high");

endmodule

/* File: test/gipb_pins_model.sv */
// Board model: resolves every pad from the device drive, outside drivers
// and resistors. Assumes the bench drives ext_val and ext_oe on ref_clk.
`timescale 1ns/1ps
module gipb_pins_model
    import gipb_pkg::*;
(
    // Clock
    input  wire logic                ref_clk,
    // Device pads
    input  wire logic [NUM_PINS-1:0] pin_out,
    input  wire logic [NUM_PINS-1:0] pin_oe,
    input  wire logic [NUM_PINS-1:0] pin_pullup,
    // Outside drivers and fitted resistors
    input  wire logic [NUM_PINS-1:0] ext_val,
    input  wire logic [NUM_PINS-1:0] ext_oe,
    input  wire logic [NUM_PINS-1:0] res_pu,
    output logic      [NUM_PINS-1:0] pin_in
);
    // ==========================================================
    // Pad resolution
    logic [NUM_PINS-1:0] drift = '0;
    // A floating pad must never show a stale level, so it toggles.
    always @(posedge ref_clk) drift <= ~drift;
    always_comb
        for (int i = 0; i < NUM_PINS; i++)
            pin_in[i] = pin_oe[i] ? pin_out[i] : ext_oe[i] ? ext_val[i]
                      : (res_pu[i] | pin_pullup[i]) ? 1'h1 : drift[i];
endmodule

/* File: test/tb_generic_io_port_bank.sv */
// Self-checking bench for the pin bank against a behavioural model.
// Assumes gipb_pins_model resolves the pads; resistors sit on peripheral pins.
`timescale 1ns/1ps
module tb_generic_io_port_bank
    import gipb_pkg::*;
;
    // ==========================================================
    // Signals and model state
    logic                      ref_clk = 1'h0;
    logic                      sys_rst = 1'h1;
    logic                      wr_en = 1'h0;
    logic                      rd_en = 1'h0;
    logic [3:0]                bank_sel = 4'h0;
    logic [1:0]                reg_sel = 2'h0;
    logic [7:0]                wr_data = 8'h00;
    logic [7:0]                rd_data;
    logic                      rd_valid;
    logic                      pu_b = 1'h0;
    logic [NUM_PINS-1:0]       p_en = '0, p_out = '0, p_oe = '0;
    logic [NUM_PINS-1:0][2:0]  od_mod = '0;
    logic [NUM_PINS-1:0]       pin_in, pin_out, pin_oe, pin_pullup;
    logic [NUM_PINS-1:0]       ext_val = '0, ext_oe = '0;
    logic [NUM_PINS-1:0]       e_out, e_oe, e_pu;
    logic [7:0]                m_dir[NUM_BANKS], m_hold[NUM_BANKS], m_pu, d;
    int                        n_fail = 0, total_checks = 0, cyc = 0, seed = 32'h2e81;

    always #2 ref_clk = ~ref_clk;

    gipb_bank DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .wr_en(wr_en), .rd_en(rd_en),
        .bank_sel(bank_sel), .reg_sel(reg_sel), .wr_data(wr_data), .rd_data(rd_data),
        .rd_valid(rd_valid), .bank_b_pullup_enable(pu_b), .periph_en(p_en),
        .periph_out(p_out), .periph_oe(p_oe), .periph_od_mod(od_mod), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup));

    gipb_pins_model board (.ref_clk(ref_clk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pullup(pin_pullup), .ext_val(ext_val), .ext_oe(ext_oe), .res_pu(p_en),
        .pin_in(pin_in));

    // ==========================================================
    // Compare tasks and verdict
    task automatic chk8(input string w, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", w, e, g);
        end
    endtask

    task automatic chkv(input string w, input logic [NUM_PINS-1:0] e, g);
        total_checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", w, e, g);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 8000)
        begin
            n_fail++;
            give_verdict();
        end
    end

    // ==========================================================
    // Model and bus tasks
    task automatic model_pads();
        int b, k, m;
        logic od;
        for (int i = 0; i < NUM_PINS; i++)
        begin
            b = i / 8;
            k = i % 8;
            m = int'(od_mod[i]);
            od = (m >= 1 && m <= 3) ? m_dir[6][m+4] : (m >= 4) ? m_hold[6][m+1] : 1'h0;
            od = od & p_en[i];
            e_oe[i] = p_en[i] ? (p_oe[i] & ~(od & p_out[i])) : ~m_dir[b][k];
            e_out[i] = p_en[i] ? (p_out[i] & ~od) : m_hold[b][k];
            e_pu[i] = (b == 1) ? pu_b : (b == 3) ? m_pu[PU_D_BIT]
                    : (b == 4) ? m_pu[PU_E_BIT] : (b == 8) ? m_pu[PU_J_BIT] : 1'h0;
        end
    endtask

    task automatic settle();
        model_pads();
        @(posedge ref_clk);
        ext_oe <= ~e_oe & ~p_en;
        repeat (4) @(posedge ref_clk);
        #1;
        chkv("pin_oe", e_oe, pin_oe);
        chkv("pin_out", e_out & e_oe, pin_out & e_oe);
        chkv("pin_pullup", e_pu, pin_pullup);
    endtask

    function automatic logic [7:0] lvl(input int b);
        logic [7:0] v;
        for (int k = 0; k < 8; k++)
            v[k] = e_oe[b*8+k] ? e_out[b*8+k] : ext_oe[b*8+k] ? ext_val[b*8+k] : 1'h1;
        if (b == 6)
            v[7:5] = m_pu[7:5];
        return v;
    endfunction

    task automatic wr(input int b, input logic [1:0] r, input logic [7:0] v);
        @(posedge ref_clk);
        wr_en <= 1'h1;
        bank_sel <= 4'(b);
        reg_sel <= r;
        wr_data <= v;
        @(posedge ref_clk);
        wr_en <= 1'h0;
        if (b < NUM_BANKS && r != 2'h3)
        begin
            if (r == REG_DIR)
                m_dir[b] = v;
            else
                m_hold[b] = v;
            if (r == REG_PIN && b == 6)
                m_pu = v & 8'he0;
        end
    endtask

    task automatic rd(input int b, input logic [1:0] r, input logic [7:0] e);
        @(posedge ref_clk);
        rd_en <= 1'h1;
        bank_sel <= 4'(b);
        reg_sel <= r;
        @(posedge ref_clk);
        rd_en <= 1'h0;
        #1;
        chk8("rd_valid", 8'h01, {7'h00, rd_valid});
        chk8("rd_data", e, rd_data);
    endtask

    // ==========================================================
    // Main sequence
    initial
    begin
        for (int b = 0; b < NUM_BANKS; b++)
        begin
            m_dir[b] = DIR_RST;
            m_hold[b] = HOLD_RST;
        end
        m_pu = 8'h00;
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'h0;
        ext_val <= NUM_PINS'({$random(seed), $random(seed), $random(seed)});
        settle();  // inputs after reset
        for (int b = 0; b < 10; b++)
        begin
            rd(b, REG_DIR, b < 9 ? DIR_RST : RD_ZERO);  // reset values
            rd(b, REG_HOLD, b < 9 ? HOLD_RST : RD_ZERO);  // hold reset
        end
        rd(0, 2'h3, RD_ZERO);  // unmapped register
        wr(9, REG_HOLD, 8'hff);  // unmapped bank write
        rd(1, REG_HOLD, HOLD_RST);  // no alias onto bank B
        $display("test reset and map done");
        for (int b = 0; b < NUM_BANKS; b++)
        begin
            d = 8'($random(seed));
            wr(b, REG_HOLD, d);  // hold value
            wr(b, REG_DIR, 8'($random(seed)));  // mixed directions
            settle();  // driven pins
            rd(b, REG_HOLD, d);  // latched value
            rd(b, REG_PIN, lvl(b));  // pin levels
            d = ~d;
            wr(b, REG_PIN, d);  // pin write
            settle();  // pads follow
            rd(b, REG_HOLD, d);  // lands in hold
        end
        $display("test direction and hold done");
        wr(0, REG_DIR, 8'hff);
        settle();
        d = lvl(0);
        @(posedge ref_clk);
        ext_val[7:0] <= ~d;
        rd_en <= 1'h1;
        bank_sel <= BANK_A;
        reg_sel <= REG_PIN;
        @(posedge ref_clk);
        rd_en <= 1'h0;
        #1;
        chk8("sync", d, rd_data);  // old level seen
        settle();
        rd(0, REG_PIN, ~d);  // new level later
        $display("test synchroniser done");
        for (int v = 0; v < 16; v++)
        begin
            @(posedge ref_clk);
            pu_b <= v[0];
            wr(6, REG_PIN, {v[3:1], 5'h00});  // enable bits
            settle();  // pull-up banks
            rd(6, REG_PIN, lvl(6));  // bits read back
        end
        $display("test pull-ups done");
        for (int t = 0; t < 6; t++)
        begin
            @(posedge ref_clk);
            p_en <= NUM_PINS'({$random(seed), $random(seed), $random(seed)});
            p_out <= NUM_PINS'({$random(seed), $random(seed), $random(seed)});
            p_oe <= NUM_PINS'({$random(seed), $random(seed), $random(seed)});
            for (int i = 0; i < NUM_PINS; i++)
                od_mod[i] <= 3'($unsigned($random(seed)) % 7);
            wr(6, REG_DIR, 8'($random(seed)));  // serial enables
            wr(6, REG_HOLD, 8'($random(seed)));  // compare enables
            settle();  // takeover and drain
            for (int b = 0; b < NUM_BANKS; b++)
                rd(b, REG_PIN, lvl(b));  // released pins high
        end
        $display("test peripherals done");
        give_verdict();
    end
endmodule
